// *** hdl/stc_regs.sv ***
// Configuration and identification register bank of the stepper terminal
`timescale 1ns/1ps
module stc_regs
  import stc_pkg::*;
#(
  parameter logic [15:0] PART_TYPE_ID = 16'h5A01,  // Arbitrary value
  parameter logic [15:0] FW_REVISION  = 16'h3130,  // Arbitrary value
  parameter logic [15:0] HW_REVISION  = 16'h0001,  // Arbitrary value
  parameter int unsigned WD_LIMIT     = WD_CYCLES,
  parameter int unsigned FILTER_LEN   = FILTER_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        enc_a_pin,
  input  wire logic        enc_b_pin,
  input  wire logic        enc_c_pin,
  input  wire logic        gate_pin,
  input  wire logic        step_pulse,
  input  wire logic        step_dir,
  input  wire logic        pd_strobe,
  output logic             special_stop,
  output logic             special_active,
  output logic             eep_wr,
  output logic      [5:0]  eep_addr,
  output logic      [15:0] eep_data,
  output logic      [15:0] status_word,
  output logic      [31:0] position,
  output logic             wd_trip,
  output logic             custom_current_table,
  output logic             ramp_shape_select,
  output logic      [1:0]  motion_mode_select,
  output logic             auto_halt_enable,
  output logic             auto_launch_enable
);
  localparam int unsigned WDW = $clog2(WD_LIMIT + 1);
  localparam logic [WDW-1:0] WD_LAST = WDW'(WD_LIMIT - 1);
  logic [15:0]    ram_ff [0:31];
  logic [31:0]    cap_mem_ff [0:LATCH_MAX-1];
  logic [15:0]    key_ff, cmd_ff;
  stc_spc_e       spc_ff;
  logic [31:0]    enc_count_ff, step_count_ff, cap_ff;
  logic [4:0]     cap_wr_ptr_ff, cap_rd_ptr_ff;
  logic [WDW-1:0] wd_cnt_ff;
  logic           a_prev_ff, b_prev_ff, gate_prev_ff;
  logic [3:0]     pin_s;
  logic [2:0]     enc_f;
  logic [15:0]    feature_config, latch_count_setting;
  logic           key_ok, user_wr, free_reg, freeze, cap_evt;
  logic [4:0]     cap_limit;
  logic [31:0]    fb_raw, fb_val;
  logic [15:0]    nxt_rdata;
  logic           enc_step, enc_down, cap_pop;
  assign feature_config      = ram_ff[IDX_FEATURE];
  assign latch_count_setting = ram_ff[IDX_LATCH_CNT];
  assign key_ok   = (key_ff == USER_KEY);
  assign user_wr  = reg_wr && reg_addr[5];
  assign free_reg = (reg_addr inside {6'h25, 6'h26, 6'h27, 6'h28, 6'h2f, 6'h30, 6'h31, 6'h32, 6'h3a});
  stc_sync #(.W(4)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({gate_pin, enc_c_pin, enc_b_pin, enc_a_pin}),
    .q       (pin_s)
  );
  for (genvar i = 0; i < 3; i++) begin : g_filt
    stc_filt #(.LEN(FILTER_LEN)) u_filt (
      .clk     (clk),
      .reset_n (reset_n),
      .bypass  (feature_config[FB_FILTER_BYP]),
      .din     (pin_s[i]),
      .dout    (enc_f[i])
    );
  end
  // Key register, cleared by restart
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      key_ff <= KEY_RST;
    end else if (reg_wr && reg_addr == ADDR_KEY) begin
      key_ff <= reg_wdata;
    end
  end
  // User page RAM and nonvolatile write strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) begin
        ram_ff[i] <= 16'h0000;
      end
      ram_ff[IDX_FEATURE]   <= FEATURE_RST;
      ram_ff[IDX_LATCH_CNT] <= LATCH_CNT_RST;
      eep_wr   <= 1'b0;
      eep_addr <= 6'h00;
      eep_data <= 16'h0000;
    end else begin
      eep_wr <= 1'b0;
      if (user_wr && key_ok) begin
        ram_ff[reg_addr[4:0]] <= reg_wdata;
        eep_wr   <= 1'b1;
        eep_addr <= reg_addr;
        eep_data <= reg_wdata;
      end else if (user_wr && free_reg) begin
        ram_ff[reg_addr[4:0]] <= reg_wdata;
      end
    end
  end
  // Command register and special command state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cmd_ff       <= 16'h0000;
      spc_ff       <= STC_SPC_IDLE;
      special_stop <= 1'b0;
    end else begin
      special_stop <= 1'b0;
      if (reg_wr && reg_addr == ADDR_CMD) begin
        cmd_ff <= reg_wdata;
        case (spc_ff)
          STC_SPC_IDLE: begin
            if (reg_wdata[15:6] == CMD_SPECIAL_BASE) begin
              spc_ff <= STC_SPC_RUN;
            end
          end
          STC_SPC_RUN: begin
            if (reg_wdata == CMD_SPECIAL_STOP) begin
              spc_ff       <= STC_SPC_IDLE;
              special_stop <= 1'b1;
            end
          end
          default: spc_ff <= STC_SPC_IDLE;
        endcase
      end
    end
  end
  // Quadrature or pulse-count decode
  always_comb begin
    if (feature_config[FB_PULSE_COUNT]) begin
      enc_step = enc_f[0] && !a_prev_ff;
      enc_down = enc_f[1];
    end else begin
      enc_step = (enc_f[0] ^ a_prev_ff) || (enc_f[1] ^ b_prev_ff);
      enc_down = !(a_prev_ff ^ enc_f[1]);
    end
  end
  assign freeze  = (feature_config[FB_HIGH_FREEZE] && pin_s[3])
                || (feature_config[FB_LOW_FREEZE] && !pin_s[3]);
  assign cap_evt = pin_s[3] && !gate_prev_ff;
  // Encoder and step counters
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      a_prev_ff     <= 1'b0;
      b_prev_ff     <= 1'b0;
      gate_prev_ff  <= 1'b0;
      enc_count_ff  <= 32'h0000_0000;
      step_count_ff <= 32'h0000_0000;
    end else begin
      a_prev_ff    <= enc_f[0];
      b_prev_ff    <= enc_f[1];
      gate_prev_ff <= pin_s[3];
      if (cap_evt && feature_config[FB_CAP_CLEAR]) begin
        enc_count_ff  <= 32'h0000_0000;
        step_count_ff <= 32'h0000_0000;
      end else begin
        if (enc_step && !freeze) begin
          enc_count_ff <= enc_down ? enc_count_ff - 32'd1 : enc_count_ff + 32'd1;
        end
        if (step_pulse) begin
          step_count_ff <= step_dir ? step_count_ff - 32'd1 : step_count_ff + 32'd1;
        end
      end
    end
  end
  assign fb_raw = feature_config[FB_FB_SOURCE] ? step_count_ff : enc_count_ff;
  assign fb_val = feature_config[FB_SIGN_INV] ? 32'd0 - fb_raw : fb_raw;
  assign cap_limit = (latch_count_setting == 16'h0000) ? 5'd1
                   : (latch_count_setting > 16'(LATCH_MAX)) ? 5'(LATCH_MAX) : latch_count_setting[4:0];
  assign cap_pop = reg_rd && reg_addr == ADDR_LATCH_HI && feature_config[FB_MULTI_CAP];
  // Position capture store
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cap_ff        <= 32'h0000_0000;
      cap_wr_ptr_ff <= 5'd0;
      cap_rd_ptr_ff <= 5'd0;
      for (int i = 0; i < LATCH_MAX; i++) begin
        cap_mem_ff[i] <= 32'h0000_0000;
      end
    end else begin
      if (cap_evt) begin
        cap_ff <= fb_val;
        if (feature_config[FB_MULTI_CAP]) begin
          cap_mem_ff[cap_wr_ptr_ff] <= fb_val;
          cap_wr_ptr_ff <= (cap_wr_ptr_ff + 5'd1 >= cap_limit) ? 5'd0 : cap_wr_ptr_ff + 5'd1;
        end
      end
      if (cap_pop) begin
        cap_rd_ptr_ff <= (cap_rd_ptr_ff + 5'd1 >= cap_limit) ? 5'd0 : cap_rd_ptr_ff + 5'd1;
      end
    end
  end
  // Process data watchdog
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wd_cnt_ff <= '0;
      wd_trip   <= 1'b0;
    end else if (feature_config[FB_WD_DISABLE] || pd_strobe) begin
      wd_cnt_ff <= '0;
      wd_trip   <= 1'b0;
    end else if (wd_cnt_ff == WD_LAST) begin
      wd_trip   <= 1'b1;
    end else begin
      wd_cnt_ff <= wd_cnt_ff + WDW'(1);
    end
  end
  // Feature outputs, position and status
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      position             <= 32'h0000_0000;
      status_word          <= 16'h0000;
      special_active       <= 1'b0;
      custom_current_table <= 1'b0;
      ramp_shape_select    <= 1'b0;
      motion_mode_select   <= 2'b00;
      auto_halt_enable     <= 1'b0;
      auto_launch_enable   <= 1'b0;
    end else begin
      position                 <= fb_val;
      status_word              <= 16'h0000;
      status_word[SB_SPECIAL]  <= (spc_ff == STC_SPC_RUN);
      status_word[SB_WD_TRIP]  <= wd_trip;
      status_word[SB_INDEX]    <= feature_config[FB_MIRROR] && enc_f[2];
      status_word[SB_GATE]     <= feature_config[FB_MIRROR] && pin_s[3];
      special_active           <= (spc_ff == STC_SPC_RUN);
      custom_current_table     <= feature_config[FB_CUR_TABLE];
      ramp_shape_select        <= feature_config[FB_RAMP_SHAPE];
      motion_mode_select       <= feature_config[FB_MODE_HI:FB_MODE_LO];
      auto_halt_enable         <= feature_config[FB_AUTO_HALT];
      auto_launch_enable       <= feature_config[FB_AUTO_LAUNCH];
    end
  end
  // Read multiplexer
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_addr[5]) begin
      nxt_rdata = ram_ff[reg_addr[4:0]];
    end else begin
      case (reg_addr)
        ADDR_POS_LO:    nxt_rdata = fb_val[15:0];
        ADDR_POS_HI:    nxt_rdata = fb_val[31:16];
        ADDR_LATCH_HI:  nxt_rdata = feature_config[FB_MULTI_CAP] ? cap_mem_ff[cap_rd_ptr_ff][31:16] : cap_ff[31:16];
        ADDR_CMD:       nxt_rdata = cmd_ff;
        ADDR_PART_TYPE: nxt_rdata = PART_TYPE_ID;
        ADDR_FW_REV:    nxt_rdata = FW_REVISION;
        ADDR_HW_REV:    nxt_rdata = HW_REVISION;
        ADDR_KEY:       nxt_rdata = key_ff;
        default:        nxt_rdata = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_rdata  <= reg_rd ? nxt_rdata : reg_rdata;
    end
  end
  // Checking helpers
  logic [4:0]  chk_idx_ff;
  logic [15:0] chk_old_ff;
  always_ff @(posedge clk) begin
    chk_idx_ff <= reg_addr[4:0];
    chk_old_ff <= ram_ff[reg_addr[4:0]];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  stop_pulse_a: assert property (reg_wr && reg_addr == ADDR_CMD && reg_wdata == CMD_SPECIAL_STOP
    |=> spc_ff == STC_SPC_IDLE ##1 !special_active && !status_word[SB_SPECIAL])
    else $error("special command not stopped");
  part_type_a: assert property (reg_rd && reg_addr == ADDR_PART_TYPE
    |=> reg_rvalid && reg_rdata == PART_TYPE_ID)
    else $error("part type readback wrong");
  fw_rev_a: assert property (reg_wr && reg_addr == ADDR_FW_REV ##[1:4] reg_rd && reg_addr == ADDR_FW_REV
    |=> reg_rdata == FW_REVISION)
    else $error("firmware revision changed by write");
  hw_rev_a: assert property (reg_rd && reg_addr == ADDR_HW_REV
    |=> reg_rvalid && reg_rdata == HW_REVISION)
    else $error("hardware revision readback wrong");
  locked_write_a: assert property (user_wr && !free_reg && !key_ok
    |=> !eep_wr && ram_ff[chk_idx_ff] == chk_old_ff)
    else $error("locked write took effect");
  eep_copy_a: assert property (user_wr && key_ok
    |=> eep_wr && eep_addr == $past(reg_addr) && eep_data == $past(reg_wdata) && ram_ff[chk_idx_ff] == eep_data)
    else $error("unlocked write not copied");
  free_ram_a: assert property (user_wr && free_reg && !key_ok
    |=> !eep_wr && ram_ff[chk_idx_ff] == $past(reg_wdata))
    else $error("free register write wrong");
  key_restart_a: assert property ($rose(reset_n) |-> key_ff == KEY_RST && !eep_wr)
    else $error("key not cleared by restart");
  high_freeze_a: assert property (feature_config[FB_HIGH_FREEZE] && pin_s[3] && !cap_evt
    |=> enc_count_ff == $past(enc_count_ff))
    else $error("counter moved while gate high");
  low_freeze_a: assert property (feature_config[FB_LOW_FREEZE] && !pin_s[3]
    |=> enc_count_ff == $past(enc_count_ff))
    else $error("counter moved while gate low");
  wd_off_a: assert property (feature_config[FB_WD_DISABLE] |=> !wd_trip && wd_cnt_ff == '0)
    else $error("watchdog active while disabled");
  key_withdraw_a: assert property (reg_wr && reg_addr == ADDR_KEY && reg_wdata != USER_KEY
    |=> !key_ok ##1 !eep_wr)
    else $error("permission kept after wrong key");
endmodule : stc_regs

// *** hdl/stc_pkg.sv ***
// Constants shared by the stepper terminal configuration register bank
package stc_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned WD_TIMEOUT_MS   = 100;
  localparam int unsigned WD_CYCLES       = WD_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned FILTER_CYCLES   = 4;
  localparam int unsigned LATCH_MAX       = 20;

  localparam logic [5:0]  ADDR_POS_LO     = 6'h00;
  localparam logic [5:0]  ADDR_POS_HI     = 6'h01;
  localparam logic [5:0]  ADDR_LATCH_HI   = 6'h05;
  localparam logic [5:0]  ADDR_CMD        = 6'h07;
  localparam logic [5:0]  ADDR_PART_TYPE  = 6'h08;
  localparam logic [5:0]  ADDR_FW_REV     = 6'h09;
  localparam logic [5:0]  ADDR_HW_REV     = 6'h10;
  localparam logic [5:0]  ADDR_KEY        = 6'h1f;
  localparam logic [5:0]  ADDR_FEATURE    = 6'h20;
  localparam logic [4:0]  IDX_FEATURE     = 5'h00;
  localparam logic [4:0]  IDX_LATCH_CNT   = 5'h05;

  localparam logic [15:0] USER_KEY        = 16'h1235;
  localparam logic [15:0] CMD_SPECIAL_STOP = 16'h0540;
  localparam logic [9:0]  CMD_SPECIAL_BASE = 10'h014;
  localparam logic [15:0] KEY_RST         = 16'h0000;
  localparam logic [15:0] FEATURE_RST     = 16'h0000;
  localparam logic [15:0] LATCH_CNT_RST   = 16'h0014;

  localparam int unsigned FB_PULSE_COUNT  = 15;
  localparam int unsigned FB_FILTER_BYP   = 14;
  localparam int unsigned FB_HIGH_FREEZE  = 13;
  localparam int unsigned FB_LOW_FREEZE   = 12;
  localparam int unsigned FB_FB_SOURCE    = 11;
  localparam int unsigned FB_MIRROR       = 10;
  localparam int unsigned FB_MULTI_CAP    = 9;
  localparam int unsigned FB_CAP_CLEAR    = 8;
  localparam int unsigned FB_CUR_TABLE    = 7;
  localparam int unsigned FB_SIGN_INV     = 6;
  localparam int unsigned FB_RAMP_SHAPE   = 5;
  localparam int unsigned FB_MODE_HI      = 4;
  localparam int unsigned FB_MODE_LO      = 3;
  localparam int unsigned FB_WD_DISABLE   = 2;
  localparam int unsigned FB_AUTO_HALT    = 1;
  localparam int unsigned FB_AUTO_LAUNCH  = 0;

  localparam int unsigned SB_SPECIAL      = 0;
  localparam int unsigned SB_WD_TRIP      = 1;
  localparam int unsigned SB_INDEX        = 3;
  localparam int unsigned SB_GATE         = 4;

  typedef enum logic [0:0] {
    STC_SPC_IDLE = 1'b0,
    STC_SPC_RUN  = 1'b1
  } stc_spc_e;
endpackage : stc_pkg

// *** hdl/stc_sync.sv ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module stc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : stc_sync

// *** hdl/stc_filt.sv ***
// Glitch filter for one encoder line, with bypass
`timescale 1ns/1ps
module stc_filt #(
  parameter int unsigned LEN = 4
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic bypass,
  input  wire logic din,
  output logic      dout
);
  localparam int unsigned CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(LEN - 1);
  logic [CW-1:0] cnt_ff;

  // Output follows input after it has stood LEN cycles, or at once when bypass is set
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      dout   <= 1'b0;
    end else if (bypass || din == dout) begin
      cnt_ff <= '0;
      dout   <= din;
    end else if (cnt_ff == CNT_MAX) begin
      cnt_ff <= '0;
      dout   <= din;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end
endmodule : stc_filt

// *** verification/stc_pin_model.sv ***
// Behavioural model of the pins and process data source facing the register bank
`timescale 1ns/1ps
module stc_pin_model (
  input  wire logic clk,
  input  wire logic pd_en,
  output logic      enc_a_pin,
  output logic      enc_b_pin,
  output logic      enc_c_pin,
  output logic      gate_pin,
  output logic      pd_strobe
);
  logic [3:0] pd_cnt_ff = 4'h0;
  initial begin
    enc_a_pin = 1'b0;
    enc_b_pin = 1'b0;
    enc_c_pin = 1'b0;
    gate_pin  = 1'b0;
    pd_strobe = 1'b0;
  end
  // Process data every 16 cycles while enabled
  always @(posedge clk) begin
    pd_cnt_ff <= pd_cnt_ff + 4'h1;
    pd_strobe <= pd_en && (pd_cnt_ff == 4'h0);
  end
  // Pulses on the A track, high for w cycles, low for 10
  task automatic pulse_a(input int n, input int w);
    repeat (n) begin
      @(posedge clk) #1;
      enc_a_pin = 1'b1;
      repeat (w) @(posedge clk);
      #1;
      enc_a_pin = 1'b0;
      repeat (10) @(posedge clk);
      #1;
    end
  endtask : pulse_a
  task automatic set_index(input logic v);
    @(posedge clk) #1;
    enc_c_pin = v;
  endtask : set_index
  task automatic set_gate(input logic v);
    @(posedge clk) #1;
    gate_pin = v;
  endtask : set_gate
endmodule : stc_pin_model

// *** verification/test_stc_regs.sv ***
// Self-checking testbench of the configuration register bank
`timescale 1ns/1ps
module test_stc_regs;
  import stc_pkg::*;
  localparam logic [15:0] TB_PART = 16'h5A01;  // Arbitrary value
  localparam logic [15:0] TB_FW   = 16'h3241;
  localparam logic [15:0] TB_HW   = 16'h0003;
  logic        clk        = 1'b0;
  logic        reset_n    = 1'b0;
  logic [5:0]  reg_addr   = 6'h00;
  logic [15:0] reg_wdata  = 16'h0000;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic        step_pulse = 1'b0;
  logic        step_dir   = 1'b0;
  logic        pd_en      = 1'b1;
  logic        enc_a_pin, enc_b_pin, enc_c_pin, gate_pin, pd_strobe;
  logic [15:0] reg_rdata, eep_data, status_word;
  logic        reg_rvalid, special_stop, special_active, eep_wr, wd_trip;
  logic [5:0]  eep_addr;
  logic [31:0] position;
  logic        custom_current_table, ramp_shape_select, auto_halt_enable, auto_launch_enable;
  logic [1:0]  motion_mode_select;
  int          failures = 0;
  int          checked  = 0;
  logic [5:0]  ram_only [9] = '{6'h25, 6'h26, 6'h27, 6'h28, 6'h2f, 6'h30, 6'h31, 6'h32, 6'h3a};

  always #5 clk = ~clk;

  stc_regs #(.PART_TYPE_ID(TB_PART), .FW_REVISION(TB_FW), .HW_REVISION(TB_HW), .WD_LIMIT(50)) i_dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .enc_a_pin(enc_a_pin),
    .enc_b_pin(enc_b_pin), .enc_c_pin(enc_c_pin), .gate_pin(gate_pin), .step_pulse(step_pulse),
    .step_dir(step_dir), .pd_strobe(pd_strobe), .special_stop(special_stop),
    .special_active(special_active), .eep_wr(eep_wr), .eep_addr(eep_addr), .eep_data(eep_data),
    .status_word(status_word), .position(position), .wd_trip(wd_trip),
    .custom_current_table(custom_current_table), .ramp_shape_select(ramp_shape_select),
    .motion_mode_select(motion_mode_select), .auto_halt_enable(auto_halt_enable),
    .auto_launch_enable(auto_launch_enable)
  );

  stc_pin_model p (
    .clk(clk), .pd_en(pd_en), .enc_a_pin(enc_a_pin), .enc_b_pin(enc_b_pin),
    .enc_c_pin(enc_c_pin), .gate_pin(gate_pin), .pd_strobe(pd_strobe)
  );

  task automatic give_verdict;
    $display("checks made %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk) #1;
    reg_wr    = 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [15:0] exp, input string what);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk) #1;
    reg_rd   = 1'b0;
    chk(reg_rvalid, 1'b1, {what, " valid"});
    chk(reg_rdata, exp, what);
  endtask : rd

  task automatic keyed(input logic [15:0] f);
    wr(ADDR_KEY, USER_KEY);
    wr(ADDR_FEATURE, f);
    cyc(3);
  endtask : keyed

  initial begin
    #100_000;
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    cyc(2);
    reset_n = 1'b1;
    rd(ADDR_KEY, KEY_RST, "key reset");
    rd(ADDR_FEATURE, FEATURE_RST, "feature reset");
    chk(custom_current_table, 1'b0, "sine table default");
    rd(6'h25, LATCH_CNT_RST, "latch count reset");
    rd(ADDR_PART_TYPE, TB_PART, "part type");
    wr(ADDR_FW_REV, 16'hFFFF);
    rd(ADDR_FW_REV, TB_FW, "firmware revision");
    chk(reg_rdata[15:8], 8'h32, "firmware first char");
    rd(ADDR_HW_REV, TB_HW, "hardware revision");
    $display("test ids done");

    wr(ADDR_FEATURE, 16'h00A9);
    chk(eep_wr, 1'b0, "keyless protected eep");
    rd(ADDR_FEATURE, 16'h0000, "keyless protected");
    foreach (ram_only[i]) begin
      wr(ram_only[i], {10'h000, ram_only[i]});
      chk(eep_wr, 1'b0, "ram only eep");
      rd(ram_only[i], {10'h000, ram_only[i]}, "ram only write");
    end
    wr(ADDR_KEY, USER_KEY);
    wr(ADDR_FEATURE, 16'h00A9);
    chk({eep_wr, eep_addr, eep_data}, {1'b1, ADDR_FEATURE, 16'h00A9}, "keyed eep");
    rd(ADDR_FEATURE, 16'h00A9, "keyed write");
    chk({custom_current_table, ramp_shape_select, motion_mode_select, auto_halt_enable, auto_launch_enable},
        6'b110101, "feature outputs");
    wr(6'h25, 16'h0007);
    chk({eep_wr, eep_addr, eep_data}, {1'b1, 6'h25, 16'h0007}, "keyed ram only eep");
    wr(ADDR_KEY, 16'h1234);
    wr(ADDR_FEATURE, 16'h0000);
    chk(eep_wr, 1'b0, "withdrawn eep");
    rd(ADDR_FEATURE, 16'h00A9, "withdrawn key");
    $display("test protection done");

    wr(ADDR_CMD, CMD_SPECIAL_STOP);
    chk(special_stop, 1'b0, "stop while idle");
    wr(ADDR_CMD, 16'h0520);
    cyc(2);
    chk({special_active, status_word[0]}, 2'b11, "special running");
    wr(ADDR_CMD, CMD_SPECIAL_STOP);
    chk(special_stop, 1'b1, "stop pulse");
    cyc(1);
    chk({special_active, special_stop}, 2'b00, "special stopped");
    $display("test command done");

    cyc(60);
    chk(wd_trip, 1'b0, "fed watchdog");
    pd_en = 1'b0;
    cyc(60);
    chk({wd_trip, status_word[1]}, 2'b11, "watchdog trip");
    pd_en = 1'b1;
    cyc(20);
    chk(wd_trip, 1'b0, "watchdog cleared");
    $display("test watchdog done");

    keyed(16'h0804);
    pd_en = 1'b0;
    repeat (3) begin
      @(posedge clk) #1;
      step_pulse = 1'b1;
      @(posedge clk) #1;
      step_pulse = 1'b0;
    end
    cyc(3);
    chk(position, 32'h0000_0003, "step feedback");
    cyc(60);
    chk(wd_trip, 1'b0, "watchdog disabled");
    keyed(16'h0844);
    chk(position, 32'hFFFF_FFFD, "inverted feedback");
    rd(ADDR_POS_LO, 16'hFFFD, "position low word");
    rd(ADDR_POS_HI, 16'hFFFF, "position high word");
    pd_en = 1'b1;
    keyed(16'h0000);
    p.pulse_a(1, 10);
    chk(position, 32'h0000_0000, "quadrature there and back");
    $display("test feedback done");

    keyed(16'h8000);
    chk(position, 32'h0000_0000, "encoder feedback idle");
    p.pulse_a(3, 10);
    chk(position, 32'h0000_0003, "pulse count");
    p.set_gate(1'b1);
    p.set_index(1'b1);
    cyc(8);
    chk(status_word[4:3], 2'b00, "mirror off");
    keyed(16'h8400);
    chk(status_word[4:3], 2'b11, "gate and index mirror");
    keyed(16'hA400);
    p.pulse_a(2, 10);
    chk(position, 32'h0000_0003, "high gate freeze");
    keyed(16'h9400);
    p.pulse_a(2, 10);
    chk(position, 32'h0000_0005, "low gate open");
    p.pulse_a(1, 2);
    chk(position, 32'h0000_0005, "glitch filtered");
    keyed(16'hD400);
    p.pulse_a(1, 2);
    chk(position, 32'h0000_0006, "filter bypassed");
    keyed(16'hD540);
    chk(position, 32'hFFFF_FFFA, "inverted before capture");
    p.set_gate(1'b0);
    p.set_gate(1'b1);
    cyc(5);
    chk(position, 32'h0000_0000, "capture clears position");
    rd(ADDR_LATCH_HI, 16'hFFFF, "single capture");
    keyed(16'hD640);
    p.set_gate(1'b0);
    p.set_gate(1'b1);
    p.pulse_a(1, 2);
    p.set_gate(1'b0);
    p.set_gate(1'b1);
    cyc(5);
    rd(ADDR_LATCH_HI, 16'h0000, "first stored capture");
    rd(ADDR_LATCH_HI, 16'hFFFF, "second stored capture");
    $display("test encoder done");

    reset_n = 1'b0;
    cyc(2);
    reset_n = 1'b1;
    rd(ADDR_KEY, KEY_RST, "key after restart");
    wr(ADDR_FEATURE, 16'h0001);
    rd(ADDR_FEATURE, 16'h0000, "locked after restart");
    $display("test restart done");
    give_verdict();
  end
endmodule : test_stc_regs
